// File: common/sbsrc_link_if.sv
`timescale 1ns/1ps
// Signals between the serial link logic and the core controller.
interface sbsrc_link_if;
	// Command events, one toggle each, made on the serial clock.
	logic save_tgl;
	logic restore_tgl;
	logic hib_tgl;
	// Core levels, already synchronised onto the serial clock.
	logic busy;
	logic accept;
	logic status_ok;
	logic [2:0] cfg;

	modport link (output save_tgl, output restore_tgl, output hib_tgl,
		input busy, input accept, input status_ok, input cfg);
	modport core (input save_tgl, input restore_tgl, input hib_tgl,
		output busy, output accept, output status_ok, output cfg);
endinterface

// File: common/sbsrc_pkg.sv
// Shared constants for the backup store and restore controller.
package sbsrc_pkg;

	// Core clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 50;

	// Store and restore durations in nanoseconds; plain defaults.
	localparam int STORE_TIME_NS = 8000000;
	localparam int RESTORE_TIME_NS = 25000;

	// Cycle counts; least times round up to whole cycles.
	localparam int STORE_CYC = (STORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESTORE_CYC = (RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Width of the duration counter.
	localparam int CNT_W = 24;

	// Command opcodes; plain defaults, supplied by the instruction set.
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_SW_SAVE = 8'hA1;
	localparam logic [7:0] OP_SW_RESTORE = 8'hA2;
	localparam logic [7:0] OP_HIBERNATE = 8'hA3;

	// Configuration bits: block protect field [1:0], save-disable bit [2].
	localparam int CFG_W = 3;
	localparam int CFG_ASE = 2;
	localparam logic [2:0] CFG_FACTORY = 3'h0;

	// Status byte positions.
	localparam int ST_BUSY = 0;
	localparam int ST_BP_LO = 2;
	localparam int ST_ASE = 6;

	// Controller states, Gray coded along the power-up, save, hibernate path.
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RESTORE = 3'h1,
		ST_IDLE = 3'h3,
		ST_SAVE = 3'h2,
		ST_HIB_SAVE = 3'h6,
		ST_HIB = 3'h7
	} sbsrc_state_t;

endpackage

// File: dv/sbsrc_props.sv
`timescale 1ns/1ps
// Timing checks on the controller's supply, transfer and status pins.
module sbsrc_props
	import sbsrc_pkg::*;
#(
	parameter logic [CNT_W-1:0] STORE_CYCLES = CNT_W'(STORE_CYC),
	parameter logic [CNT_W-1:0] RESTORE_CYCLES = CNT_W'(RESTORE_CYC)
) (
	// Clock and reset.
	input wire logic MCLK,
	input wire logic RST_N,
	// Supply comparators and array writes.
	input wire logic VCAP_ABOVE_TRIP,
	input wire logic VCC_ABOVE_VCAP,
	input wire logic ARRAY_WR,
	// Controller outputs.
	input wire logic NV_SAVE,
	input wire logic NV_RESTORE,
	input wire logic VCC_CONNECT,
	input wire logic LOW_POWER,
	input wire logic BUSY,
	input wire logic ARRAY_MODIFIED
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Cycles spent so far in the running save and restore.
	logic [CNT_W-1:0] save_cnt_r;
	logic [CNT_W-1:0] rest_cnt_r;
	// Both counters restart whenever their transfer is not running.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			save_cnt_r <= '0;
			rest_cnt_r <= '0;
		end else begin
			save_cnt_r <= NV_SAVE ? save_cnt_r + 1'b1 : '0;
			rest_cnt_r <= NV_RESTORE ? rest_cnt_r + 1'b1 : '0;
		end
	end
	property p_save_len;
		$fell(NV_SAVE) |-> save_cnt_r == STORE_CYCLES;
	endproperty
	a_save_len: assert property (p_save_len) else $error("save ran a wrong length");
	property p_rest_max;
		NV_RESTORE |-> rest_cnt_r < RESTORE_CYCLES;
	endproperty
	a_rest_max: assert property (p_rest_max) else $error("restore overran");
	property p_busy;
		BUSY == (NV_SAVE || NV_RESTORE);
	endproperty
	a_busy: assert property (p_busy) else $error("busy disagrees with transfers");
	property p_disc;
		$fell(VCC_CONNECT) |-> !$past(VCAP_ABOVE_TRIP, 3);
	endproperty
	a_disc: assert property (p_disc) else $error("supply opened without a drop");
	property p_recon;
		$rose(VCC_CONNECT) |-> !$past(NV_SAVE) && $past(VCC_ABOVE_VCAP);
	endproperty
	a_recon: assert property (p_recon) else $error("supply closed too early");
	property p_lowpwr;
		$rose(LOW_POWER) |-> !ARRAY_MODIFIED && !BUSY;
	endproperty
	a_lowpwr: assert property (p_lowpwr) else $error("low power before save");
	property p_mod;
		ARRAY_WR |=> ARRAY_MODIFIED;
	endproperty
	a_mod: assert property (p_mod) else $error("write did not mark array");
	property p_low;
		!VCAP_ABOVE_TRIP [*4] |-> !NV_RESTORE;
	endproperty
	a_low: assert property (p_low) else $error("restore kept below trip");
	// A rise seen while no transfer runs must start a restore after the sync delay.
	property p_rise;
		$rose(VCAP_ABOVE_TRIP) && !BUSY && !LOW_POWER |-> ##[1:4] NV_RESTORE;
	endproperty
	a_rise: assert property (p_rise) else $error("rise did not restore");
	// A save that ends with the supply back leaves the array valid, so no restore follows.
	property p_no_restore;
		$fell(NV_SAVE) && VCAP_ABOVE_TRIP |-> !NV_RESTORE [*4];
	endproperty
	a_no_restore: assert property (p_no_restore) else $error("restore after save");
endmodule

bind sbsrc_top sbsrc_props #(
	.STORE_CYCLES(STORE_CYCLES),
	.RESTORE_CYCLES(RESTORE_CYCLES)
) sbsrc_props_i (
	.MCLK(MCLK), .RST_N(RST_N), .VCAP_ABOVE_TRIP(VCAP_ABOVE_TRIP),
	.VCC_ABOVE_VCAP(VCC_ABOVE_VCAP), .ARRAY_WR(ARRAY_WR), .NV_SAVE(NV_SAVE),
	.NV_RESTORE(NV_RESTORE), .VCC_CONNECT(VCC_CONNECT), .LOW_POWER(LOW_POWER),
	.BUSY(BUSY), .ARRAY_MODIFIED(ARRAY_MODIFIED)
);

// File: dv/sbsrc_spi_model.sv
`timescale 1ns/1ps
// Serial master; its clock idles low between frames, period 125 ns.
module sbsrc_spi_model (
	// Serial pins toward the device.
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe,
	// High when the device drove its output during the last frame.
	output logic seen
);
	// Idle bus at time zero.
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		seen = 1'b0;
	end
	// Sends one opcode, then keeps clocking nb bytes in.
	task automatic frame(input logic [7:0] op, input int nb, output logic [31:0] rx);
		logic b;
		b = 1'b0;
		rx = '0;
		seen = 1'b0;
		#31 cs_n = 1'b0;
		for (int i = 0; i < 8 + 8 * nb; i++) begin
			si = (i < 8) ? op[7 - i] : ~si;
			#62.5 sck = 1'b1;
			if (i >= 8) begin
				// A released line shows the inverse of the last bit.
				b = so_oe ? so : ~b;
				seen = seen | so_oe;
				rx = {rx[30:0], b};
			end
			#62.5 sck = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		#100;
	endtask
endmodule

// File: dv/sram_backup_store_recall_control_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench; counts of transfer cycles form the reference model.
module sram_backup_store_recall_control_tb_top;
	import sbsrc_pkg::*;
	localparam int SC = 80;
	localparam int RC = 10;
	// Core inputs, driven on the rising edge.
	logic mclk = 1'b0, rst_n = 1'b0, vcap = 1'b1, vcc = 1'b1, wr = 1'b0, cwr = 1'b0;
	logic [2:0] cdin = 3'h0;
	logic sck, cs_n, si, so, so_oe, nv_save, nv_rst, vcon, lowp, busy, amod;
	logic [2:0] cfg, c;
	logic [31:0] rx;
	logic [7:0] rnd = 8'h3D;
	int n_mismatch = 0, check_count = 0, cyc = 0, hs = 0, hr = 0, s0 = 0, r0 = 0;

	sbsrc_top #(.STORE_CYCLES(CNT_W'(SC)), .RESTORE_CYCLES(CNT_W'(RC))) sbsrc_top_i (
		.MCLK(mclk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
		.VCAP_ABOVE_TRIP(vcap), .VCC_ABOVE_VCAP(vcc), .ARRAY_WR(wr), .STATUS_CFG_WR(cwr),
		.STATUS_CFG_DIN(cdin), .NV_SAVE(nv_save), .NV_RESTORE(nv_rst), .VCC_CONNECT(vcon),
		.LOW_POWER(lowp), .BUSY(busy), .ARRAY_MODIFIED(amod), .STATUS_CFG(cfg));
	sbsrc_spi_model spi (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .seen());

	// Core clock, 50 ns period.
	initial begin
		forever #25 mclk = ~mclk;
	end
	// Counts cycles spent saving and restoring, and cuts a hang short.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		hs <= hs + (nv_save === 1'b1);
		hr <= hr + (nv_rst === 1'b1);
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Compares transfer cycles since the last mark with the model's count.
	task automatic mark(input int es, input int er);
		chk(16'(hs - s0), 16'(es));
		chk(16'(hr - r0), 16'(er));
		s0 = hs;
		r0 = hr;
		$display("test done at %0t", $time);
	endtask
	task automatic wcfg(input logic [2:0] v);
		@(posedge mclk);
		cwr <= 1'b1;
		cdin <= v;
		@(posedge mclk);
		cwr <= 1'b0;
		idle(2);
	endtask
	task automatic wpulse();
		@(posedge mclk);
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		idle(2);
	endtask
	// Expected status byte: busy at bit 0, protect at 3:2, save-disable at 6.
	function automatic logic [15:0] stb(input logic b, input logic [2:0] v);
		return {9'h0, v[2], 2'h0, v[1:0], 1'h0, b};
	endfunction
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	initial begin
		idle(3);
		rst_n <= 1'b1;
		idle(40);
		mark(0, RC);
		spi.frame(OP_STATUS_READ, 1, rx);
		chk(16'(rx[7:0]), stb(1'b0, 3'h0));
		chk(16'(cfg), 16'h0);
		// Software save while unmodified, then a restore refused while busy.
		rnd = lfsr(rnd);
		c = {1'b0, rnd[1:0]};
		wcfg(c);
		spi.frame(OP_SW_SAVE, 0, rx);
		spi.frame(OP_SW_RESTORE, 0, rx);
		spi.frame(OP_STATUS_READ, 4, rx);
		chk(16'(rx[31:24]), stb(1'b1, c));
		chk(16'(rx[7:0]), stb(1'b0, c));
		idle(20);
		mark(SC, 0);
		wcfg(c ^ 3'h3);
		spi.frame(OP_SW_RESTORE, 0, rx);
		idle(RC + 20);
		mark(0, RC);
		chk(16'(cfg), 16'(c));
		// Power loss with a modified array; supply returns during the save.
		wpulse();
		chk(16'(amod), 16'h1);
		@(posedge mclk) vcc <= 1'b0;
		@(posedge mclk) vcap <= 1'b0;
		idle(6);
		chk(16'(vcon), 16'h0);
		spi.frame(OP_STATUS_READ, 1, rx);
		chk(16'(spi.seen), 16'h0);
		@(posedge mclk) vcap <= 1'b1;
		@(posedge mclk) vcc <= 1'b1;
		idle(10);
		chk(16'(vcon), 16'h0);
		idle(SC);
		mark(SC, 0);
		chk(16'(vcon), 16'h1);
		chk(16'(amod), 16'h0);
		// Save disabled: no save; a restore cut short by another loss.
		wcfg({1'b1, c[1:0]});
		wpulse();
		@(posedge mclk) vcap <= 1'b0;
		idle(10);
		mark(0, 0);
		@(posedge mclk) vcap <= 1'b1;
		idle(5);
		@(posedge mclk) vcap <= 1'b0;
		idle(10);
		chk(16'(hr - r0 < RC && hr > r0 && hs == s0), 16'h1);
		chk(16'(amod), 16'h1);
		s0 = hs;
		r0 = hr;
		@(posedge mclk) vcap <= 1'b1;
		idle(RC + 10);
		mark(0, RC);
		chk(16'(cfg), 16'(c));
		chk(16'(amod), 16'h0);
		// Hibernate with a modified array, then wake by chip select.
		wpulse();
		spi.frame(OP_HIBERNATE, 0, rx);
		idle(SC + 10);
		mark(SC, 0);
		chk(16'(lowp), 16'h1);
		spi.frame(OP_STATUS_READ, 1, rx);
		idle(RC + 10);
		mark(0, RC);
		chk(16'(lowp), 16'h0);
		// Hibernate with a clean array skips the save; a power cycle wakes it.
		spi.frame(OP_HIBERNATE, 0, rx);
		idle(10);
		mark(0, 0);
		chk(16'(lowp), 16'h1);
		@(posedge mclk) vcap <= 1'b0;
		idle(10);
		chk(16'(lowp), 16'h0);
		@(posedge mclk) vcap <= 1'b1;
		idle(RC + 10);
		mark(0, RC);
		chk(16'(cfg), 16'(c));
		spi.frame(OP_STATUS_READ, 1, rx);
		chk(16'(rx[7:0]), stb(1'b0, c));
		chk(16'(busy), 16'h0);
		results();
	end
endmodule

// File: rtl/sbsrc_link.sv
`timescale 1ns/1ps
// Serial command front end, clocked by the master's serial clock.
module sbsrc_link
	import sbsrc_pkg::*;
(
	// Serial clock and global reset.
	input wire logic sck,
	input wire logic rst_n,
	// Serial pins.
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Core side.
	sbsrc_link_if.link lk
);
	// Frame end clears all per-frame state, since the clock stops between frames.
	logic frame_rst;
	// Bit position within the current byte.
	logic [2:0] bit_cnt_r;
	// High while the opcode byte is still arriving.
	logic op_phase_r;
	// Opcode shift register.
	logic [7:0] op_r;
	// High once a status read has been accepted in this frame.
	logic stat_r;
	// Outgoing shift register.
	logic [7:0] tx_r;
	// The full opcode as it completes on the eighth edge.
	logic [7:0] op_full;
	// Opcode completes on this edge.
	logic op_done;

	assign frame_rst = cs_n | ~rst_n;
	assign op_full = {op_r[6:0], si};
	assign op_done = op_phase_r && (bit_cnt_r == 3'h7);

	// Builds the status byte from the current core levels.
	function automatic logic [7:0] status_byte(input logic bsy, input logic [2:0] c);
		logic [7:0] b;
		b = 8'h00;
		b[ST_BUSY] = bsy;
		b[ST_BP_LO +: 2] = c[1:0];
		b[ST_ASE] = c[CFG_ASE];
		return b;
	endfunction

	// Receive path: count bits and capture the opcode.
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt_r <= 3'h0;
			op_phase_r <= 1'b1;
			op_r <= 8'h00;
			stat_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (op_phase_r) begin
				op_r <= op_full;
			end
			if (op_done) begin
				op_phase_r <= 1'b0;
				// Status read is the one command allowed while busy.
				if (op_full == OP_STATUS_READ && lk.status_ok) begin
					stat_r <= 1'b1;
				end
			end
		end
	end

	// Command events toggle so the core sees each one exactly once.
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			lk.save_tgl <= 1'b0;
			lk.restore_tgl <= 1'b0;
			lk.hib_tgl <= 1'b0;
		end else if (op_done && lk.accept) begin
			case (op_full)
				OP_SW_SAVE: begin
					lk.save_tgl <= ~lk.save_tgl;
				end
				OP_SW_RESTORE: begin
					lk.restore_tgl <= ~lk.restore_tgl;
				end
				OP_HIBERNATE: begin
					lk.hib_tgl <= ~lk.hib_tgl;
				end
				default: begin
				end
			endcase
		end
	end

	// Transmit path: reload fresh status at every byte boundary.
	always_ff @(negedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			tx_r <= 8'h00;
			so_oe <= 1'b0;
		end else begin
			so_oe <= stat_r;
			if (stat_r && bit_cnt_r == 3'h0) begin
				tx_r <= status_byte(lk.busy, lk.cfg);
			end else begin
				tx_r <= {tx_r[6:0], 1'b0};
			end
		end
	end

	assign so = tx_r[7];
endmodule

// File: rtl/sbsrc_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for a group of independent levels.
module sbsrc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Destination clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// First stage; only the second stage reads it.
	logic [W-1:0] meta_r;

	// Each bit crosses on its own, so a multi-bit group may skew by a cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// File: rtl/sbsrc_top.sv
`timescale 1ns/1ps
module sbsrc_top
	import sbsrc_pkg::*;
#(
	// Durations in core cycles; shorten these in simulation.
	parameter logic [CNT_W-1:0] STORE_CYCLES = CNT_W'(STORE_CYC),
	parameter logic [CNT_W-1:0] RESTORE_CYCLES = CNT_W'(RESTORE_CYC)
) (
	// Core clock and reset.
	input wire logic MCLK,
	input wire logic RST_N,
	// Serial link, clocked by the master.
	input wire logic SCK,
	input wire logic CS_N,
	input wire logic SI,
	output logic SO,
	output logic SO_OE,
	// Supply monitor comparators.
	input wire logic VCAP_ABOVE_TRIP,
	input wire logic VCC_ABOVE_VCAP,
	// Array data path, on the core clock.
	input wire logic ARRAY_WR,
	input wire logic STATUS_CFG_WR,
	input wire logic [CFG_W-1:0] STATUS_CFG_DIN,
	// Controls to the backup cells and power switch.
	output logic NV_SAVE,
	output logic NV_RESTORE,
	output logic VCC_CONNECT,
	output logic LOW_POWER,
	// Status to the rest of the device.
	output logic BUSY,
	output logic ARRAY_MODIFIED,
	output logic [CFG_W-1:0] STATUS_CFG
);
	// Link signals between the serial front end and this core.
	sbsrc_link_if lk ();

	// Synchronised pin levels and event toggles.
	logic cs_n_s;
	logic vcap_ok_s;
	logic vcc_ok_s;
	logic save_tgl_s;
	logic restore_tgl_s;
	logic hib_tgl_s;
	// Previous values for edge detection.
	logic vcap_ok_q;
	logic save_tgl_q;
	logic restore_tgl_q;
	logic hib_tgl_q;
	// Decoded single-cycle events.
	logic vcap_rise;
	logic vcap_fall;
	logic save_evt;
	logic restore_evt;
	logic hib_evt;
	// Controller state and duration counter.
	sbsrc_state_t state_r;
	logic [CNT_W-1:0] cnt_r;
	// Hibernate request waiting for chip select to go high.
	logic hib_pend_r;
	// Array modified since the last completed transfer.
	logic modified_r;
	// Live and backed-up configuration bits.
	logic [CFG_W-1:0] cfg_r;
	logic [CFG_W-1:0] nv_cfg_r;
	// Supply switch open.
	logic vcc_disc_r;
	// Transfer finishing in this cycle.
	logic save_done;
	logic restore_done;
	// Levels sent to the link.
	logic busy;
	logic accept;
	logic status_ok;

	// True in any state that copies the array into backup.
	function automatic logic is_saving(input sbsrc_state_t s);
		return (s == ST_SAVE) || (s == ST_HIB_SAVE);
	endfunction

	// True in the save and restore states, which refuse commands other than status read.
	function automatic logic is_busy(input sbsrc_state_t s);
		return is_saving(s) || (s == ST_RESTORE);
	endfunction

	// Pins and link toggles cross into the core clock domain.
	sbsrc_sync #(.W(6), .RST_VAL(6'h20)) u_sync_core (
		.clk(MCLK),
		.rst_n(RST_N),
		.d({CS_N, VCAP_ABOVE_TRIP, VCC_ABOVE_VCAP,
			lk.save_tgl, lk.restore_tgl, lk.hib_tgl}),
		.q({cs_n_s, vcap_ok_s, vcc_ok_s, save_tgl_s, restore_tgl_s, hib_tgl_s})
	);

	// Core levels cross onto the serial clock. The serial clock only runs
	// inside frames, so the first two edges of a frame may show stale values.
	sbsrc_sync #(.W(6), .RST_VAL(6'h00)) u_sync_link (
		.clk(SCK),
		.rst_n(RST_N),
		.d({busy, accept, status_ok, cfg_r}),
		.q({lk.busy, lk.accept, lk.status_ok, lk.cfg})
	);

	// Serial command front end.
	sbsrc_link u_link (
		.sck(SCK),
		.rst_n(RST_N),
		.cs_n(CS_N),
		.si(SI),
		.so(SO),
		.so_oe(SO_OE),
		.lk(lk)
	);

	// Edge history of the synchronised levels.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			vcap_ok_q <= 1'b0;
			save_tgl_q <= 1'b0;
			restore_tgl_q <= 1'b0;
			hib_tgl_q <= 1'b0;
		end else begin
			vcap_ok_q <= vcap_ok_s;
			save_tgl_q <= save_tgl_s;
			restore_tgl_q <= restore_tgl_s;
			hib_tgl_q <= hib_tgl_s;
		end
	end

	// The history resets low, so a supply already above trip at reset
	// release still counts as the first power-up.
	assign vcap_rise = vcap_ok_s & ~vcap_ok_q;
	assign vcap_fall = ~vcap_ok_s & vcap_ok_q;
	assign save_evt = save_tgl_s ^ save_tgl_q;
	assign restore_evt = restore_tgl_s ^ restore_tgl_q;
	assign hib_evt = hib_tgl_s ^ hib_tgl_q;

	// A transfer ends when its counter runs out; a restore cut by power loss
	// does not count as finished.
	assign save_done = is_saving(state_r) && (cnt_r == '0);
	assign restore_done = (state_r == ST_RESTORE) && (cnt_r == '0) && !vcap_fall;

	// Main sequencer for save, restore and hibernation.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= ST_OFF;
			cnt_r <= '0;
		end else begin
			case (state_r)
				// Supply below trip or never seen; wait for it to rise.
				ST_OFF: begin
					if (vcap_rise) begin
						state_r <= ST_RESTORE;
						cnt_r <= RESTORE_CYCLES - CNT_W'(1);
					end
				end
				// Restore runs its full time unless power drops.
				ST_RESTORE: begin
					if (vcap_fall) begin
						state_r <= ST_OFF;
					end else if (cnt_r == '0) begin
						state_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// Ready for commands.
				ST_IDLE: begin
					if (vcap_fall) begin
						// Auto save only with saving enabled and a dirty array.
						if (!cfg_r[CFG_ASE] && modified_r) begin
							state_r <= ST_SAVE;
							cnt_r <= STORE_CYCLES - CNT_W'(1);
						end else begin
							state_r <= ST_OFF;
						end
					end else if (save_evt) begin
						state_r <= ST_SAVE;
						cnt_r <= STORE_CYCLES - CNT_W'(1);
					end else if (restore_evt) begin
						state_r <= ST_RESTORE;
						cnt_r <= RESTORE_CYCLES - CNT_W'(1);
					end else if (hib_pend_r && cs_n_s) begin
						// Hibernation saves only a dirty array.
						if (modified_r) begin
							state_r <= ST_HIB_SAVE;
							cnt_r <= STORE_CYCLES - CNT_W'(1);
						end else begin
							state_r <= ST_HIB;
						end
					end
				end
				// Save ignores supply changes until it ends.
				ST_SAVE: begin
					if (cnt_r == '0) begin
						// Supply back means the array is still good.
						state_r <= vcap_ok_s ? ST_IDLE : ST_OFF;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// Save on the way into hibernation.
				ST_HIB_SAVE: begin
					if (cnt_r == '0) begin
						state_r <= vcap_ok_s ? ST_HIB : ST_OFF;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				// Low power until chip select falls or power cycles.
				ST_HIB: begin
					if (vcap_fall) begin
						state_r <= ST_OFF;
					end else if (!cs_n_s) begin
						state_r <= ST_RESTORE;
						cnt_r <= RESTORE_CYCLES - CNT_W'(1);
					end
				end
				default: begin
					state_r <= ST_OFF;
					cnt_r <= '0;
				end
			endcase
		end
	end

	// A hibernate request waits in idle for the end of its frame.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			hib_pend_r <= 1'b0;
		end else if (state_r != ST_IDLE || vcap_fall) begin
			hib_pend_r <= 1'b0;
		end else if (hib_evt) begin
			hib_pend_r <= 1'b1;
		end
	end

	// Dirty flag; a write in the finishing cycle wins over the clear.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			modified_r <= 1'b0;
		end else if (ARRAY_WR) begin
			modified_r <= 1'b1;
		end else if (save_done || restore_done) begin
			modified_r <= 1'b0;
		end
	end

	// Configuration bits follow every completed save and restore; a restore cut by power loss leaves them unchanged.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_r <= CFG_FACTORY;
			nv_cfg_r <= CFG_FACTORY;
		end else begin
			if (save_done) begin
				nv_cfg_r <= cfg_r;
			end
			if (restore_done) begin
				cfg_r <= nv_cfg_r;
			end else if (STATUS_CFG_WR && state_r == ST_IDLE) begin
				cfg_r <= STATUS_CFG_DIN;
			end
		end
	end

	// Supply switch: open on a drop, closed again only once the main
	// supply is above the capacitor and no save is running, so a fast
	// capacitor discharge cannot make the switch chatter.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			vcc_disc_r <= 1'b0;
		end else if (vcap_fall) begin
			vcc_disc_r <= 1'b1;
		end else if (vcc_ok_s && !is_saving(state_r)) begin
			vcc_disc_r <= 1'b0;
		end
	end

	// Levels seen by the link: nothing is taken below trip or in hibernation.
	assign busy = is_busy(state_r);
	assign accept = (state_r == ST_IDLE) && vcap_ok_s && !hib_pend_r;
	assign status_ok = vcap_ok_s && (state_r != ST_OFF) && (state_r != ST_HIB);

	// Outputs decode registered state.
	assign NV_SAVE = is_saving(state_r);
	assign NV_RESTORE = (state_r == ST_RESTORE);
	assign VCC_CONNECT = ~vcc_disc_r;
	assign LOW_POWER = (state_r == ST_HIB);
	assign BUSY = busy;
	assign ARRAY_MODIFIED = modified_r;
	assign STATUS_CFG = cfg_r;
endmodule
